/* File: design/rpas_top.sv */
// apb slave for pointer based packet ram access and second setup register
//
// The APB slave port was decided locally.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - setup bit 3 enables enhanced functions
// - setup bit 2 drops line idle need
// - bits 1:0 pick reconfiguration timer period
// - ram reached only through pointer registers
// - high first; low write loads address
// - address load prefetches byte into data
// - data register read returns prefetched byte
// - auto increment advances pointer and prefetches
// - data writes go via temporary register
// - pointer registers are readable
module rpas_top
  import rpas_pkg::*;
#(
  parameter int RCT0_CYCLES = RCT0_CYC,
  parameter int RCT1_CYCLES = RCT1_CYC,
  parameter int RCT2_CYCLES = RCT2_CYC,
  parameter int RCT3_CYCLES = RCT3_CYC
)(
  input  wire logic              ref_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ABUS_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output var  logic              pready_o,
  output var  logic [31:0]       prdata_o,
  output var  logic              pslverr_o,
  input  wire logic              line_idle_i,
  input  wire logic              reconfig_restart_i,
  output var  logic              clock_multiplier_select_hi_o,
  output var  logic              clock_multiplier_select_lo_o,
  output var  logic              enhanced_function_enable_o,
  output var  logic              line_idle_check_disable_o,
  output var  logic [1:0]        reconfig_timeout_select_o,
  output var  logic              ram_init_allowed_o,
  output var  logic              core_stopped_o,
  output var  logic              reconfig_expired_o
);

  function automatic logic reg_hit(input logic [ABUS_W-1:0] a,
                                   input logic [5:0]        idx);
    reg_hit = (a == {idx, 2'b00});
  endfunction : reg_hit

  function automatic logic [1:0] eff_ckm(input logic [1:0] sel);
    eff_ckm = (sel == CKM_40MHZ) ? CKM_40MHZ : CKM_20MHZ;
  endfunction : eff_ckm

  typedef struct packed {
    rpas_state_t       state;
    logic [7:0]        hi;
    logic [RAM_AW-1:0] ptr;
    logic              autoinc;
    logic [7:0]        data;
    logic [7:0]        temp;
    logic [S2_W-1:0]   s2;
    logic [1:0]        ckm;
    logic              stopped;
    logic              idle_s1;
    logic              idle_s2;
    logic              init_ok;
    logic              pready;
    logic [7:0]        prdata;
    logic              pslverr;
  } rpas_regs_t;

  rpas_regs_t        st_q;
  rpas_regs_t        st_d;
  logic              acc;
  logic              wr_acc;
  logic              rd_acc;
  logic              ram_we;
  logic              ram_re;
  logic [7:0]        ram_rdata;
  logic              mapped;
  logic [7:0]        rd_val;

  assign acc    = psel_i & penable_i & st_q.pready;
  assign wr_acc = acc & pwrite_i;
  assign rd_acc = acc & ~pwrite_i;
  // ram requests from the access engine
  assign ram_we = (st_q.state == ST_COMMIT);
  assign ram_re = (st_q.state == ST_FETCH);

  always_comb
  begin
    mapped = reg_hit(paddr_i, IDX_PTR_HI) | reg_hit(paddr_i, IDX_PTR_LO)
           | reg_hit(paddr_i, IDX_DATA)   | reg_hit(paddr_i, IDX_SETUP2)
           | reg_hit(paddr_i, IDX_RESTART);
    rd_val = 8'h00;
    if (reg_hit(paddr_i, IDX_PTR_HI))
    begin
      rd_val = {st_q.autoinc, 4'h0, st_q.ptr[RAM_AW-1:8]};
    end
    else if (reg_hit(paddr_i, IDX_PTR_LO))
    begin
      rd_val = st_q.ptr[7:0];
    end
    else if (reg_hit(paddr_i, IDX_DATA))
    begin
      rd_val = st_q.data;
    end
    else if (reg_hit(paddr_i, IDX_SETUP2))
    begin
      rd_val = {2'b00, st_q.s2};
    end
  end

  always_comb
  begin
    st_d         = st_q;
    st_d.idle_s1 = line_idle_i;
    st_d.idle_s2 = st_q.idle_s1;
    st_d.init_ok = st_q.s2[S2_LINE_IDLE_CHECK_DISABLE] | st_q.idle_s2;
    st_d.ckm     = eff_ckm(st_q.s2[S2_CKM_HI:S2_CKM_LO]);

    // apb answer: one wait state, held off while the engine is busy
    st_d.pready  = psel_i & penable_i & ~st_q.pready
                 & (st_q.state == ST_IDLE);
    st_d.prdata  = st_q.pready ? 8'h00 : rd_val;
    st_d.pslverr = psel_i & penable_i & ~st_q.pready
                 & (st_q.state == ST_IDLE) & ~mapped;

    unique case (st_q.state)
      ST_IDLE:
      begin
        if (wr_acc && reg_hit(paddr_i, IDX_PTR_HI))
        begin
          st_d.hi = pwdata_i[7:0];
        end
        if (wr_acc && reg_hit(paddr_i, IDX_PTR_LO))
        begin
          // full address loaded on low write
          st_d.ptr     = {st_q.hi[PH_ADDR_MSB:0], pwdata_i[7:0]};
          st_d.autoinc = st_q.hi[PH_AUTOINC];
          st_d.state   = ST_FETCH;
        end
        if (wr_acc && reg_hit(paddr_i, IDX_DATA))
        begin
          st_d.temp  = pwdata_i[7:0];
          st_d.state = ST_COMMIT;
        end
        if (rd_acc && reg_hit(paddr_i, IDX_DATA) && st_q.autoinc)
        begin
          st_d.ptr   = st_q.ptr + RAM_AW'(1);
          st_d.state = ST_FETCH;
        end
        if (wr_acc && reg_hit(paddr_i, IDX_SETUP2))
        begin
          st_d.s2 = pwdata_i[S2_W-1:0];
          if (pwdata_i[S2_CKM_HI:S2_CKM_LO] != st_q.s2[S2_CKM_HI:S2_CKM_LO])
          begin
            st_d.stopped = 1'b1;
          end
        end
        if (wr_acc && reg_hit(paddr_i, IDX_RESTART)
            && pwdata_i[7:0] == RESTART_CMD)
        begin
          st_d.stopped = 1'b0;
        end
      end
      ST_COMMIT:
      begin
        if (st_q.autoinc)
        begin
          st_d.ptr = st_q.ptr + RAM_AW'(1);
        end
        st_d.state = ST_FETCH;
      end
      ST_FETCH:
      begin
        st_d.state = ST_LATCH;
      end
      ST_LATCH:
      begin
        st_d.data  = ram_rdata;
        st_d.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      st_q       <= '0;
      st_q.state <= ST_IDLE;
      st_q.s2    <= S2_RESET;
      st_q.ckm   <= CKM_20MHZ;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  rpas_pkt_ram u_ram (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .we_i      (ram_we),
    .re_i      (ram_re),
    .addr_i    (st_q.ptr),
    .wdata_i   (st_q.temp),
    .rdata_o   (ram_rdata)
  );

  rpas_rcfg_timer #(
    .P0_CYC (RCT0_CYCLES),
    .P1_CYC (RCT1_CYCLES),
    .P2_CYC (RCT2_CYCLES),
    .P3_CYC (RCT3_CYCLES)
  ) u_rct (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .sel_i     (st_q.s2[S2_RCT_MSB:0]),
    .restart_i (reconfig_restart_i),
    .expired_o (reconfig_expired_o)
  );

  assign pready_o                     = st_q.pready;
  assign prdata_o                     = {24'h000000, st_q.prdata};
  assign pslverr_o                    = st_q.pslverr;
  assign clock_multiplier_select_hi_o = st_q.ckm[1];
  assign clock_multiplier_select_lo_o = st_q.ckm[0];
  assign enhanced_function_enable_o   = st_q.s2[S2_EF];
  assign line_idle_check_disable_o    = st_q.s2[S2_LINE_IDLE_CHECK_DISABLE];
  assign reconfig_timeout_select_o    = st_q.s2[S2_RCT_MSB:0];
  assign ram_init_allowed_o           = st_q.init_ok;
  assign core_stopped_o               = st_q.stopped;

  ptr_load_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (wr_acc && reg_hit(paddr_i, IDX_PTR_LO) && st_q.state == ST_IDLE)
    |=> st_q.ptr == {$past(st_q.hi[PH_ADDR_MSB:0]), $past(pwdata_i[7:0])})
    else $error("pointer not loaded from high and low bytes");

  load_prefetch_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (wr_acc && reg_hit(paddr_i, IDX_PTR_LO) && st_q.state == ST_IDLE)
    |=> st_q.state == ST_FETCH ##1 st_q.state == ST_LATCH
        ##1 (st_q.state == ST_IDLE && st_q.data == $past(ram_rdata)))
    else $error("address load did not prefetch");

  data_read_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (rd_acc && reg_hit(paddr_i, IDX_DATA))
    |-> prdata_o[7:0] == $past(st_q.data))
    else $error("data read not the prefetched byte");

  read_advance_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (rd_acc && reg_hit(paddr_i, IDX_DATA) && st_q.autoinc
     && st_q.state == ST_IDLE)
    |=> (st_q.ptr == RAM_AW'($past(st_q.ptr) + 1) && st_q.state == ST_FETCH))
    else $error("auto increment missing after read");

  ptr_wrap_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (st_q.state == ST_COMMIT && st_q.autoinc && (&st_q.ptr))
    |=> st_q.ptr == {RAM_AW{1'b0}})
    else $error("pointer did not wrap");

  write_commit_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (wr_acc && reg_hit(paddr_i, IDX_DATA) && st_q.state == ST_IDLE)
    |=> (ram_we && st_q.temp == $past(pwdata_i[7:0])) ##1 ram_re)
    else $error("data write not committed");

  ptr_read_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (rd_acc && reg_hit(paddr_i, IDX_PTR_LO))
    |-> prdata_o[7:0] == $past(st_q.ptr[7:0]))
    else $error("pointer low readback wrong");

  ckm_reserved_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (wr_acc && reg_hit(paddr_i, IDX_SETUP2) && pwdata_i[S2_CKM_HI])
    |=> ##1 (!clock_multiplier_select_hi_o && !clock_multiplier_select_lo_o))
    else $error("reserved multiplier not mapped to default");

  ef_follow_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (wr_acc && reg_hit(paddr_i, IDX_SETUP2))
    |=> enhanced_function_enable_o == $past(pwdata_i[S2_EF]))
    else $error("enhanced enable not updated");

  // init gate needs idle or disable
  init_gate_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    ram_init_allowed_o |-> ($past(line_idle_check_disable_o) || $past(st_q.idle_s2)))
    else $error("ram init allowed while line busy");

  line_idle_check_disable_follow_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (wr_acc && reg_hit(paddr_i, IDX_SETUP2))
    |=> line_idle_check_disable_o == $past(pwdata_i[S2_LINE_IDLE_CHECK_DISABLE]))
    else $error("idle check disable not updated");

  ckm_fast_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (wr_acc && reg_hit(paddr_i, IDX_SETUP2)
     && pwdata_i[S2_CKM_HI:S2_CKM_LO] == CKM_40MHZ)
    |=> ##1 (!clock_multiplier_select_hi_o && clock_multiplier_select_lo_o))
    else $error("fast multiplier code not applied");

  no_inc_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (rd_acc && reg_hit(paddr_i, IDX_DATA) && !st_q.autoinc)
    |=> (st_q.ptr == $past(st_q.ptr) && st_q.state == ST_IDLE))
    else $error("pointer moved without auto increment");

  unmapped_err_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (psel_i && penable_i && pready_o && !mapped) |-> pslverr_o)
    else $error("unmapped access without slave error");

  err_with_ready_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    pslverr_o |-> pready_o)
    else $error("slave error outside ready");

endmodule : rpas_top
`default_nettype wire

/* File: design/rpas_pkg.sv */
// constants and types for the packet ram pointer access and setup block
package rpas_pkg;
  localparam int          RAM_AW      = 11;
  localparam int          RAM_DEPTH   = 2048;
  localparam int          ABUS_W      = 8;
  // register indices; byte address is four times the index
  localparam logic [5:0]  IDX_PTR_HI  = 6'h02;
  localparam logic [5:0]  IDX_PTR_LO  = 6'h03;
  localparam logic [5:0]  IDX_DATA    = 6'h04;
  localparam logic [5:0]  IDX_SETUP2  = 6'h05;
  localparam logic [5:0]  IDX_RESTART = 6'h07;
  // pointer high fields
  localparam int          PH_AUTOINC  = 7;
  localparam int          PH_ADDR_MSB = 2;
  // second setup fields
  localparam int          S2_CKM_HI   = 5;
  localparam int          S2_CKM_LO   = 4;
  localparam int          S2_EF       = 3;
  localparam int          S2_LINE_IDLE_CHECK_DISABLE   = 2;
  localparam int          S2_RCT_MSB  = 1;
  localparam int          S2_W        = 6;
  localparam logic [5:0]  S2_RESET    = 6'h00;
  localparam logic [1:0]  CKM_20MHZ   = 2'h0;
  localparam logic [1:0]  CKM_40MHZ   = 2'h1;
  localparam logic [7:0]  RESTART_CMD = 8'h18;
  // timing
  localparam int          CLK_PERIOD_NS = 100;
  localparam int          RCT0_US     = 420000;
  localparam int          RCT1_US     = 105000;
  localparam int          RCT2_US     = 52500;
  localparam int          RCT3_US     = 26250;
  localparam int          RCT_CW      = 23;
  localparam int          RCT0_CYC    = RCT0_US * 1000 / CLK_PERIOD_NS;
  localparam int          RCT1_CYC    = RCT1_US * 1000 / CLK_PERIOD_NS;
  localparam int          RCT2_CYC    = RCT2_US * 1000 / CLK_PERIOD_NS;
  localparam int          RCT3_CYC    = RCT3_US * 1000 / CLK_PERIOD_NS;

  typedef enum logic [1:0] {ST_IDLE, ST_COMMIT, ST_FETCH, ST_LATCH} rpas_state_t;
endpackage : rpas_pkg

/* File: design/rpas_pkt_ram.sv */
// 2k x 8 packet ram, single port, registered read
`timescale 1ns/100ps
`default_nettype none
module rpas_pkt_ram
  import rpas_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              we_i,
  input  wire logic              re_i,
  input  wire logic [RAM_AW-1:0] addr_i,
  input  wire logic [7:0]        wdata_i,
  output var  logic [7:0]        rdata_o
);
  logic [7:0] mem [RAM_DEPTH];

  always_ff @(posedge ref_clk_i)
  begin
    if (we_i)
    begin
      mem[addr_i] <= wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      rdata_o <= 8'h00;
    end
    else if (re_i)
    begin
      rdata_o <= mem[addr_i];
    end
  end
endmodule : rpas_pkt_ram
`default_nettype wire

/* File: design/rpas_rcfg_timer.sv */
// reconfiguration timer with selectable period
`timescale 1ns/100ps
`default_nettype none
module rpas_rcfg_timer
  import rpas_pkg::*;
#(
  parameter int P0_CYC = RCT0_CYC,
  parameter int P1_CYC = RCT1_CYC,
  parameter int P2_CYC = RCT2_CYC,
  parameter int P3_CYC = RCT3_CYC
)(
  input  wire logic       ref_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic [1:0] sel_i,
  input  wire logic       restart_i,
  output var  logic       expired_o
);
  logic [RCT_CW-1:0] cnt_q;
  logic [1:0]        sel_q;
  logic [RCT_CW-1:0] period;

  always_comb
  begin
    unique case (sel_i)
      2'h0: period = RCT_CW'(P0_CYC);
      2'h1: period = RCT_CW'(P1_CYC);
      2'h2: period = RCT_CW'(P2_CYC);
      2'h3: period = RCT_CW'(P3_CYC);
    endcase
  end

  // a new selection or activity restarts the full period
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      cnt_q     <= {RCT_CW{1'b0}};
      sel_q     <= 2'h0;
      expired_o <= 1'b0;
    end
    else
    begin
      sel_q     <= sel_i;
      expired_o <= 1'b0;
      // load the full count so a pulse falls exactly one period on
      if (restart_i || sel_q != sel_i || cnt_q == {RCT_CW{1'b0}})
      begin
        cnt_q <= period;
      end
      else if (cnt_q == RCT_CW'(1))
      begin
        cnt_q     <= period;
        expired_o <= 1'b1;
      end
      else
      begin
        cnt_q <= cnt_q - RCT_CW'(1);
      end
    end
  end
endmodule : rpas_rcfg_timer
`default_nettype wire

/* File: tb/rpas_host_model.sv */
// apb host model for the pointer access register port
`timescale 1ns/100ps
`default_nettype none
module rpas_host_model
  import rpas_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              pready_i,
  input  wire logic [31:0]       prdata_i,
  output var  logic              psel_o,
  output var  logic              penable_o,
  output var  logic              pwrite_o,
  output var  logic [ABUS_W-1:0] paddr_o,
  output var  logic [31:0]       pwdata_o
);
  initial
  begin
    psel_o    = 1'b0;
    penable_o = 1'b0;
    pwrite_o  = 1'b0;
    paddr_o   = 8'h00;
    pwdata_o  = 32'h0;
  end

  // one transfer, entered right after a rising edge
  task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
                      output logic [31:0] rd);
    psel_o    <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o  <= wr;
    paddr_o   <= {idx, 2'h0};
    pwdata_o  <= {24'h0, wd};
    @(posedge ref_clk_i);
    penable_o <= 1'b1;
    do @(posedge ref_clk_i); while (pready_i !== 1'b1);
    rd = prdata_i;
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
    @(posedge ref_clk_i);
  endtask : xfer

  task automatic load_ptr(input logic inc, input logic [10:0] a);
    logic [31:0] rd;
    xfer(1'b1, IDX_PTR_HI, {inc, 4'h0, a[10:8]}, rd);
    xfer(1'b1, IDX_PTR_LO, a[7:0], rd);
    repeat (2) @(posedge ref_clk_i);
  endtask : load_ptr

  task automatic restart_core();
    logic [31:0] rd;
    repeat (10000) @(posedge ref_clk_i);
    xfer(1'b1, IDX_RESTART, RESTART_CMD, rd);
  endtask : restart_core
endmodule : rpas_host_model
`default_nettype wire

/* File: tb/tb_ram_pointer_access_setup.sv */
// self-checking bench for the pointer access and setup block
`timescale 1ns/100ps
`default_nettype none
module tb_ram_pointer_access_setup;
  import rpas_pkg::*;
  logic              clk;
  logic              rst_b;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ABUS_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic              pready;
  logic [31:0]       prdata;
  logic              line_idle;
  logic              rc_restart;
  logic              ckm_hi;
  logic              ckm_lo;
  logic              ef;
  logic              line_idle_check_disable;
  logic [1:0]        rct;
  logic              init_ok;
  logic              stopped;
  logic [31:0]       rd;
  logic              pslverr;
  logic              err_seen;
  logic              rc_exp;
  logic [7:0]        mem [RAM_DEPTH];
  int                bad_count;
  int                samples_checked;
  // short timer periods so expiry can be measured
  localparam int     TB_RCT [4] = '{40, 30, 20, 10};

  rpas_top #(.RCT0_CYCLES(TB_RCT[0]), .RCT1_CYCLES(TB_RCT[1]), .RCT2_CYCLES(TB_RCT[2]),
             .RCT3_CYCLES(TB_RCT[3])) DUT (
    .ref_clk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
    .prdata_o(prdata), .pslverr_o(pslverr), .line_idle_i(line_idle),
    .reconfig_restart_i(rc_restart), .clock_multiplier_select_hi_o(ckm_hi),
    .clock_multiplier_select_lo_o(ckm_lo), .enhanced_function_enable_o(ef),
    .line_idle_check_disable_o(line_idle_check_disable), .reconfig_timeout_select_o(rct),
    .ram_init_allowed_o(init_ok), .core_stopped_o(stopped), .reconfig_expired_o(rc_exp));

  rpas_host_model HOST (
    .ref_clk_i(clk), .pready_i(pready), .prdata_i(prdata), .psel_o(psel),
    .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic int rct_period(input int code);
    rct_period = TB_RCT[code];
  endfunction : rct_period

  // error flag as taken at the ready edge
  always @(posedge clk)
  begin
    if (psel && penable && pready)
    begin
      err_seen <= pslverr;
    end
  end

  task automatic give_verdict();
    if (bad_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial
  begin
    repeat (60000) @(posedge clk);
    bad_count++;
    give_verdict();
  end

  initial
  begin
    logic [10:0] a;
    logic [10:0] e;
    logic [7:0]  d;
    logic [5:0]  v;
    int          n;
    rst_b      = 1'b0;
    line_idle  = 1'b0;
    rc_restart = 1'b0;
    bad_count  = 0;
    samples_checked = 0;
    void'($urandom(13596));
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    HOST.xfer(1'b0, IDX_SETUP2, 8'h00, rd);
    chk("setup2 reset", 32'h0, rd);
    chk("init gate at reset", 32'h0, {31'h0, init_ok});
    // setup2 fields over every timeout code
    for (int c = 0; c < 4; c++)
    begin
      v = {2'b00, 2'($urandom), 2'(c)};
      line_idle <= 1'($urandom);
      HOST.xfer(1'b1, IDX_SETUP2, {2'h0, v}, rd);
      repeat (4) @(posedge clk);
      chk("ef", {31'h0, v[3]}, {31'h0, ef});
      chk("line_idle_check_disable", {31'h0, v[2]}, {31'h0, line_idle_check_disable});
      chk("init gate", {31'h0, v[2] | line_idle}, {31'h0, init_ok});
      chk("timeout sel", {30'h0, v[1:0]}, {30'h0, rct});
      @(posedge clk iff rc_exp === 1'b1);
      n = 0;
      do
      begin
        @(posedge clk);
        n++;
      end
      while (rc_exp !== 1'b1 && n < 100);
      chk("timer period", rct_period(c), n);
      rc_restart <= 1'b1;
      @(posedge clk);
      rc_restart <= 1'b0;
      n = 0;
      do
      begin
        @(posedge clk);
        n++;
      end
      while (rc_exp !== 1'b1 && n < 100);
      // pulse rises a period after the restart edge, seen one edge later
      chk("timer restart", rct_period(c) + 1, n);
    end
    // multiplier codes, ef set for every code
    for (int c = 1; c < 4; c++)
    begin
      HOST.xfer(1'b1, IDX_SETUP2, {2'h0, 2'(c), 4'h8}, rd);
      repeat (2) @(posedge clk);
      chk("core stopped", 32'h1, {31'h0, stopped});
      chk("mult hi", 32'h0, {31'h0, ckm_hi});
      chk("mult lo", {31'h0, c == 1}, {31'h0, ckm_lo});
      HOST.restart_core();
      repeat (2) @(posedge clk);
      chk("core running", 32'h0, {31'h0, stopped});
    end
    // sequential writes then readback, first pass wraps
    for (int k = 0; k < 3; k++)
    begin
      a = (k == 0) ? 11'h7FD : 11'($urandom);
      n = 3 + $urandom % 6;
      e = a + 11'(n);
      HOST.load_ptr(1'b1, a);
      for (int i = 0; i < n; i++)
      begin
        d = 8'($urandom);
        mem[a + 11'(i)] = d;
        HOST.xfer(1'b1, IDX_DATA, d, rd);
      end
      HOST.xfer(1'b0, IDX_PTR_HI, 8'h00, rd);
      chk("ptr high", {24'h0, 5'h10, e[10:8]}, rd);
      HOST.xfer(1'b0, IDX_PTR_LO, 8'h00, rd);
      chk("ptr low", {24'h0, e[7:0]}, rd);
      HOST.load_ptr(1'b1, a);
      for (int i = 0; i < n; i++)
      begin
        HOST.xfer(1'b0, IDX_DATA, 8'h00, rd);
        chk("ram byte", {24'h0, mem[a + 11'(i)]}, rd);
      end
    end
    HOST.load_ptr(1'b0, a);
    repeat (2)
    begin
      HOST.xfer(1'b0, IDX_DATA, 8'h00, rd);
      chk("held byte", {24'h0, mem[a]}, rd);
    end
    chk("no slave error", 32'h0, {31'h0, err_seen});
    HOST.xfer(1'b1, 6'h06, 8'h5A, rd);
    chk("write slave error", 32'h1, {31'h0, err_seen});
    HOST.xfer(1'b0, 6'h06, 8'h00, rd);
    chk("unmapped read", 32'h0, rd);
    chk("read slave error", 32'h1, {31'h0, err_seen});
    give_verdict();
  end
endmodule : tb_ram_pointer_access_setup
`default_nettype wire
